/* logic/reset_source_sequencer.sv */
// Reset source sequencer: power-on delay, pin drive, cause sampling, vector select
// How it works
// - Power-on, pin, watchdog, clock monitor all reset fully
// - Power-on and pin share one vector
// - Vector fetched within three cycles after release
// - Vector pair from cause and mode page
// - Reset aborts work, clears control state
// - Power-on waits 4064 clocks before pin check
// - Pin low after delay holds reset
// - Drive pin low four bus cycles
// - Sample two bus cycles later; no internal event pending means external
// - Pending clock monitor, else watchdog, event gives internal vector
// - Watchdog times out unless serviced in time
// - Service with 0x55 then 0xAA
// - Period 2^15 times 1/4/16/64, rate resets 0
// - Watchdog on in normal modes unless disabled
`timescale 1ns/100ps
`default_nettype none
module reset_source_sequencer #(
    parameter int unsigned E_DIV     = 4,
    parameter int unsigned WDG_LOG2  = 15
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        reset_pin_in,
    output logic             reset_pin_out,
    output logic             reset_pin_oe,
    input  wire logic        clk_fail,
    input  wire logic        special_mode,
    input  wire logic        watchdog_disable,
    input  wire logic        service_wr,
    input  wire logic [7:0]  service_data,
    input  wire logic        rate_wr,
    input  wire logic [1:0]  rate_data,
    output logic             core_reset,
    output logic             vector_req,
    output logic [15:0]      vector_addr,
    output logic [1:0]       reset_cause
);
    localparam int unsigned DRIVE_CLKS  = reset_seq_pkg::DRIVE_E_CYC * E_DIV;
    localparam int unsigned SAMPLE_CLKS = reset_seq_pkg::SAMPLE_E_CYC * E_DIV;
    initial begin
        if (E_DIV < 2 || E_DIV > 64) $error("E_DIV out of range");
    end

    typedef enum logic [2:0] {
        ST_POR_WAIT, ST_PIN_WAIT, ST_DRIVE, ST_SETTLE, ST_EXT_HOLD, ST_FETCH_HI, ST_FETCH_LO, ST_RUN
    } seq_state_t;

    seq_state_t           state_q;
    logic [11:0]          cnt_q;
    logic [5:0]           ediv_q;
    logic                 e_tick_q;
    logic [1:0]           pin_sync_q;
    logic [1:0]           fail_sync_q;
    logic [1:0]           mode_sync_q;
    logic                 pin_s;
    logic                 fail_s;
    logic                 special_s;
    logic                 wdg_pend_q;
    logic                 cmon_pend_q;
    reset_seq_pkg::cause_t cause_q;
    logic                 reset_pin_oe_q;
    logic                 core_reset_q;
    logic                 vector_req_q;
    logic [15:0]          vector_addr_q;
    logic [7:0]           vec_lo;
    logic [7:0]           vec_page;
    wdg_if                wlink ();

    assign pin_s     = pin_sync_q[1];
    assign fail_s    = fail_sync_q[1];
    assign special_s = mode_sync_q[1];

    // Pins and the analog monitor are asynchronous to clk
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_sync_q  <= 2'h0;
            fail_sync_q <= 2'h0;
            mode_sync_q <= 2'h0;
        end else begin
            pin_sync_q  <= {pin_sync_q[0], reset_pin_in};
            fail_sync_q <= {fail_sync_q[0], clk_fail};
            mode_sync_q <= {mode_sync_q[0], special_mode};
        end
    end

    // Bus clock phase for the watchdog
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ediv_q   <= '0;
            e_tick_q <= 1'b0;
        end else begin
            ediv_q   <= (ediv_q == 6'(E_DIV - 1)) ? '0 : ediv_q + 6'h01;
            e_tick_q <= ediv_q == 6'(E_DIV - 1);
        end
    end

    assign wlink.sys_in_reset = core_reset_q;
    assign wlink.e_tick       = e_tick_q;
    assign wlink.enable       = !special_s && !watchdog_disable;
    assign wlink.special      = special_s;

    watchdog_timer #(.BASE_LOG2(WDG_LOG2)) u_wdg (
        .clk          (clk),
        .rst_b        (rst_b),
        .lnk          (wlink.dog),
        .service_wr   (service_wr),
        .service_data (service_data),
        .rate_wr      (rate_wr),
        .rate_data    (rate_data)
    );

    // Internal events; set wins over the clear at fetch end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wdg_pend_q  <= 1'b0;
            cmon_pend_q <= 1'b0;
        end else begin
            if (wlink.timeout) begin
                wdg_pend_q <= 1'b1;
            end else if (state_q == ST_FETCH_LO) begin
                wdg_pend_q <= 1'b0;
            end
            if (fail_s) begin
                cmon_pend_q <= 1'b1;
            end else if (state_q == ST_FETCH_LO) begin
                cmon_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q        <= ST_POR_WAIT;
            cnt_q          <= '0;
            cause_q        <= reset_seq_pkg::CAUSE_EXT;
            reset_pin_oe_q <= 1'b0;
            core_reset_q   <= 1'b1;
        end else begin
            case (state_q)
                ST_POR_WAIT: begin
                    cnt_q <= cnt_q + 12'h001;
                    if (cnt_q == 12'(reset_seq_pkg::POR_DELAY_CYC - 1)) begin
                        state_q <= ST_PIN_WAIT;
                        cause_q <= reset_seq_pkg::CAUSE_EXT;
                    end
                end
                ST_PIN_WAIT: begin
                    if (pin_s) begin
                        state_q      <= ST_FETCH_HI;
                        core_reset_q <= 1'b0;
                    end
                end
                ST_DRIVE: begin
                    cnt_q <= cnt_q + 12'h001;
                    if (cnt_q == 12'(DRIVE_CLKS - 1)) begin
                        state_q        <= ST_SETTLE;
                        reset_pin_oe_q <= 1'b0;
                        cnt_q          <= '0;
                    end
                end
                ST_SETTLE: begin
                    cnt_q <= cnt_q + 12'h001;
                    if (cnt_q == 12'(SAMPLE_CLKS - 1)) begin
                        if (cmon_pend_q || fail_s) begin
                            cause_q <= reset_seq_pkg::CAUSE_CMON;
                            state_q <= ST_EXT_HOLD;
                        end else if (wdg_pend_q || wlink.timeout) begin
                            cause_q <= reset_seq_pkg::CAUSE_WDG;
                            state_q <= ST_EXT_HOLD;
                        end else begin
                            cause_q <= reset_seq_pkg::CAUSE_EXT;
                            state_q <= ST_EXT_HOLD;
                        end
                    end
                end
                ST_EXT_HOLD: begin
                    // An external holder keeps the core down until release
                    if (pin_s) begin
                        state_q      <= ST_FETCH_HI;
                        core_reset_q <= 1'b0;
                    end
                end
                ST_FETCH_HI: begin
                    state_q <= ST_FETCH_LO;
                end
                ST_FETCH_LO: begin
                    state_q <= ST_RUN;
                end
                ST_RUN: begin
                    if (!pin_s || fail_s || wlink.timeout) begin
                        state_q        <= ST_DRIVE;
                        reset_pin_oe_q <= 1'b1;
                        core_reset_q   <= 1'b1;
                        cnt_q          <= '0;
                    end
                end
                default: begin
                    state_q <= ST_POR_WAIT;
                end
            endcase
        end
    end

    always_comb begin
        case (cause_q)
            reset_seq_pkg::CAUSE_CMON: vec_lo = reset_seq_pkg::VEC_LO_CMON;
            reset_seq_pkg::CAUSE_WDG:  vec_lo = reset_seq_pkg::VEC_LO_WDG;
            default:                   vec_lo = reset_seq_pkg::VEC_LO_EXT;
        endcase
        vec_page = special_s ? reset_seq_pkg::VEC_PAGE_SPEC : reset_seq_pkg::VEC_PAGE_NORM;
    end

    // Even vector address first, odd address (bit 0 set) on the next cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vector_req_q  <= 1'b0;
            vector_addr_q <= 16'h0000;
        end else if ((state_q == ST_PIN_WAIT || state_q == ST_EXT_HOLD) && pin_s) begin
            vector_req_q  <= 1'b1;
            vector_addr_q <= {vec_page, vec_lo};
        end else if (state_q == ST_FETCH_HI) begin
            vector_addr_q <= {vector_addr_q[15:1], 1'b1};
        end else if (state_q == ST_FETCH_LO) begin
            vector_req_q  <= 1'b0;
        end
    end

    assign reset_pin_out = 1'b0;
    assign reset_pin_oe  = reset_pin_oe_q;
    assign core_reset    = core_reset_q;
    assign vector_req    = vector_req_q;
    assign vector_addr   = vector_addr_q;
    assign reset_cause   = cause_q;

    logic [11:0] oe_len_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oe_len_q <= '0;
        end else begin
            oe_len_q <= reset_pin_oe_q ? oe_len_q + 12'h001 : '0;
        end
    end

    a_drive_len: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(reset_pin_oe_q) |-> oe_len_q == 12'(DRIVE_CLKS))
        else $error("Pin drive length wrong");
    a_por_delay: assert property (@(posedge clk) disable iff (!rst_b)
        $past(state_q) == ST_POR_WAIT && state_q != ST_POR_WAIT
        |-> $past(cnt_q) == 12'(reset_seq_pkg::POR_DELAY_CYC - 1))
        else $error("Power-on delay wrong");
    a_hold_low: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == ST_PIN_WAIT && !pin_s |=> core_reset_q && state_q == ST_PIN_WAIT)
        else $error("Left reset while pin low");
    a_fetch_soon: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(core_reset_q) |-> vector_req_q ##1 vector_req_q ##1 !vector_req_q && state_q == ST_RUN)
        else $error("Vector fetch not within three cycles");
    a_vec_pair: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(vector_req_q) |=> vector_addr_q == $past(vector_addr_q) + 16'h0001)
        else $error("Vector pair not consecutive");
    a_vec_page: assert property (@(posedge clk) disable iff (!rst_b)
        vector_req_q |-> vector_addr_q[15:8] == (special_s ? reset_seq_pkg::VEC_PAGE_SPEC
                                                           : reset_seq_pkg::VEC_PAGE_NORM))
        else $error("Vector page wrong for mode");
    a_wdg_vector: assert property (@(posedge clk) disable iff (!rst_b)
        vector_req_q && cause_q == reset_seq_pkg::CAUSE_WDG |-> vector_addr_q[7:1] == 7'h7D)
        else $error("Watchdog vector wrong");
    a_internal_prio: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == ST_SETTLE && cnt_q == 12'(SAMPLE_CLKS - 1) && (wdg_pend_q || cmon_pend_q)
        |=> cause_q != reset_seq_pkg::CAUSE_EXT)
        else $error("Internal cause lost to external");
    a_sample_ext: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == ST_SETTLE && cnt_q == 12'(SAMPLE_CLKS - 1) && !wdg_pend_q && !cmon_pend_q
        && !fail_s && !wlink.timeout |=> cause_q == reset_seq_pkg::CAUSE_EXT)
        else $error("Low sample not classed external");
    a_run_reset: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == ST_RUN && wlink.timeout |=> core_reset_q && reset_pin_oe_q)
        else $error("Watchdog timeout did not reset");
endmodule
`default_nettype wire

/* logic/reset_seq_pkg.sv */
// Constants shared by the reset sequencer and its watchdog
`default_nettype none
package reset_seq_pkg;
    localparam int unsigned POR_DELAY_CYC  = 4064;
    localparam int unsigned DRIVE_E_CYC    = 4;
    localparam int unsigned SAMPLE_E_CYC   = 2;
    localparam int unsigned RATE_WINDOW_E  = 64;
    localparam logic [7:0]  VEC_PAGE_NORM  = 8'hFF;
    localparam logic [7:0]  VEC_PAGE_SPEC  = 8'hBF;
    localparam logic [7:0]  VEC_LO_EXT     = 8'hFE;
    localparam logic [7:0]  VEC_LO_CMON    = 8'hFC;
    localparam logic [7:0]  VEC_LO_WDG     = 8'hFA;
    localparam logic [7:0]  WDG_KEY_ARM    = 8'h55;
    localparam logic [7:0]  WDG_KEY_CLEAR  = 8'hAA;
    localparam logic [1:0]  WDG_RATE_RESET = 2'h0;
    typedef enum logic [1:0] {CAUSE_EXT, CAUSE_CMON, CAUSE_WDG} cause_t;
endpackage
`default_nettype wire

/* logic/wdg_if.sv */
// Link between the sequencer and the watchdog
`timescale 1ns/100ps
`default_nettype none
interface wdg_if;
    logic sys_in_reset;
    logic e_tick;
    logic enable;
    logic special;
    logic timeout;
    modport seq (output sys_in_reset, output e_tick, output enable, output special, input timeout);
    modport dog (input sys_in_reset, input e_tick, input enable, input special, output timeout);
endinterface
`default_nettype wire

/* logic/watchdog_timer.sv */
// Free-running watchdog with keyed service and rate select, write-once outside special mode
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer #(
    parameter int unsigned BASE_LOG2 = 15
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    wdg_if.dog              lnk,
    input  wire logic       service_wr,
    input  wire logic [7:0] service_data,
    input  wire logic       rate_wr,
    input  wire logic [1:0] rate_data
);
    localparam int unsigned W = BASE_LOG2 + 6;
    initial begin
        if (BASE_LOG2 < 2 || BASE_LOG2 > 24) $error("BASE_LOG2 out of range");
    end

    logic [W-1:0] count_q;
    logic         armed_q;
    logic [1:0]   watchdog_rate_sel_q;
    logic         rate_locked_q;
    logic [6:0]   window_q;
    logic         timeout_q;
    logic [W-1:0] terminal;
    logic         clear_hit;

    // Period is 2^BASE scaled by 1, 4, 16 or 64
    assign terminal  = {W{1'b1}} >> (3'h6 - {watchdog_rate_sel_q, 1'b0});
    assign clear_hit = service_wr && service_data == reset_seq_pkg::WDG_KEY_CLEAR && armed_q;
    assign lnk.timeout = timeout_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            armed_q <= 1'b0;
        end else if (lnk.sys_in_reset) begin
            armed_q <= 1'b0;
        end else if (service_wr && service_data == reset_seq_pkg::WDG_KEY_ARM) begin
            armed_q <= 1'b1;
        end else if (clear_hit) begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q   <= '0;
            timeout_q <= 1'b0;
        end else if (lnk.sys_in_reset || !lnk.enable || clear_hit) begin
            count_q   <= '0;
            timeout_q <= 1'b0;
        end else if (lnk.e_tick) begin
            count_q   <= (count_q == terminal) ? '0 : count_q + 1'b1;
            timeout_q <= count_q == terminal;
        end else begin
            timeout_q <= 1'b0;
        end
    end

    // Late rate writes in normal modes would let runaway code stretch the period
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            watchdog_rate_sel_q <= reset_seq_pkg::WDG_RATE_RESET;
            rate_locked_q       <= 1'b0;
            window_q            <= '0;
        end else if (lnk.sys_in_reset) begin
            watchdog_rate_sel_q <= reset_seq_pkg::WDG_RATE_RESET;
            rate_locked_q       <= 1'b0;
            window_q            <= '0;
        end else begin
            if (lnk.e_tick && window_q != 7'(reset_seq_pkg::RATE_WINDOW_E)) begin
                window_q <= window_q + 7'h01;
            end
            if (rate_wr && (lnk.special || !rate_locked_q)) begin
                watchdog_rate_sel_q <= rate_data;
                rate_locked_q       <= 1'b1;
            end else if (window_q == 7'(reset_seq_pkg::RATE_WINDOW_E)) begin
                rate_locked_q <= 1'b1;
            end
        end
    end

    a_clear_count: assert property (@(posedge clk) disable iff (!rst_b)
        clear_hit && !lnk.sys_in_reset |=> count_q == '0 && !armed_q)
        else $error("Keyed service did not clear the count");
    a_rate_reset: assert property (@(posedge clk) disable iff (!rst_b)
        lnk.sys_in_reset |=> watchdog_rate_sel_q == reset_seq_pkg::WDG_RATE_RESET)
        else $error("Rate field not cleared by reset");
    a_no_clear_unarmed: assert property (@(posedge clk) disable iff (!rst_b)
        !armed_q && lnk.e_tick && lnk.enable && !lnk.sys_in_reset && count_q != terminal
        |=> count_q == $past(count_q) + 1'b1)
        else $error("Count did not advance");
endmodule
`default_nettype wire

/* bench/reset_pin_board.sv */
// Board side of the reset pin: pull-up and an external reset switch
`timescale 1ns/100ps
`default_nettype none
module reset_pin_board (
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic hold_low,
    output logic      pin_level
);
    // Plain pull-up, no RC delay, so a release is seen at once
    always_comb begin
        if (pin_oe) begin
            pin_level = pin_out;
        end else begin
            pin_level = !hold_low;
        end
    end
endmodule
`default_nettype wire

/* bench/test_reset_source_sequencer.sv */
// Self-checking bench for the reset source sequencer
`timescale 1ns/100ps
`default_nettype none
module test_reset_source_sequencer;
    localparam int unsigned EDIV = 4;
    logic        clk;
    logic        rst_b;
    logic        hold_low;
    logic        clk_fail;
    logic        special_mode;
    logic        watchdog_disable;
    logic        service_wr;
    logic [7:0]  service_data;
    logic        rate_wr;
    logic [1:0]  rate_data;
    logic        pin_level;
    logic        reset_pin_out;
    logic        reset_pin_oe;
    logic        core_reset;
    logic        vector_req;
    logic [15:0] vector_addr;
    logic [1:0]  reset_cause;
    int          error_cnt;
    int          checked;
    int          n;

    // Short watchdog base keeps rate-0 timeouts to tens of cycles
    reset_source_sequencer #(.E_DIV(EDIV), .WDG_LOG2(4)) reset_source_sequencer_i (
        .clk(clk), .rst_b(rst_b), .reset_pin_in(pin_level),
        .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
        .clk_fail(clk_fail), .special_mode(special_mode),
        .watchdog_disable(watchdog_disable), .service_wr(service_wr),
        .service_data(service_data), .rate_wr(rate_wr), .rate_data(rate_data),
        .core_reset(core_reset), .vector_req(vector_req),
        .vector_addr(vector_addr), .reset_cause(reset_cause));

    reset_pin_board reset_pin_board_i (
        .pin_out(reset_pin_out), .pin_oe(reset_pin_oe),
        .hold_low(hold_low), .pin_level(pin_level));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic end_sim;
        $display("Errors %0d, checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic sig(input int sel);
        return (sel == 0) ? core_reset : (sel == 1) ? vector_req : reset_pin_oe;
    endfunction

    // Bounded wait; count of cycles left in n
    task automatic wait_until(input int sel, input logic lvl, input int lim);
        n = 0;
        while (sig(sel) !== lvl) begin
            if (n >= lim) begin
                error_cnt++;
                $display("CHECK FAILED wait %0d expected %b seen timeout", sel, lvl);
                end_sim();
            end
            tick(1);
            n++;
        end
    endtask

    task automatic fetch(input logic [15:0] addr, input logic [1:0] cause, input int lim);
        wait_until(1, 1'b1, lim);
        check("core_reset at fetch", 16'h0, 16'(core_reset));
        check("vector low byte", addr, vector_addr);
        check("cause", 16'(cause), 16'(reset_cause));
        tick(1);
        check("vector high byte", addr | 16'h0001, vector_addr);
        tick(1);
        check("fetch end", 16'h0, 16'(vector_req));
    endtask

    task automatic service(input logic [7:0] d);
        service_wr = 1'b1;
        service_data = d;
        tick(1);
        service_wr = 1'b0;
    endtask

    task automatic por_delay;
        fetch({reset_seq_pkg::VEC_PAGE_NORM, reset_seq_pkg::VEC_LO_EXT}, 2'h0, 5000);
        check("power-on delay", 16'h1, 16'(n >= reset_seq_pkg::POR_DELAY_CYC &&
              n <= reset_seq_pkg::POR_DELAY_CYC + 10));
    endtask

    task automatic por_hold;
        rst_b = 1'b0;
        hold_low = 1'b1;
        tick(3);
        rst_b = 1'b1;
        tick(4200);
        check("held in reset", 16'h1, 16'(core_reset));
        check("no fetch while held", 16'h0, 16'(vector_req));
        check("power-on leaves pin", 16'h0, 16'(reset_pin_oe));
        hold_low = 1'b0;
        fetch({reset_seq_pkg::VEC_PAGE_NORM, reset_seq_pkg::VEC_LO_EXT}, 2'h0, 8);
    endtask

    task automatic clock_fail_reset(input logic spec);
        special_mode = spec;
        tick(4);
        clk_fail = 1'b1;
        wait_until(2, 1'b1, 8);
        clk_fail = 1'b0;
        check("core held", 16'h1, 16'(core_reset));
        check("reset pin level", 16'h0, 16'(pin_level));
        wait_until(2, 1'b0, 40);
        check("pin drive width", 16'(4 * EDIV), 16'(n));
        fetch({spec ? reset_seq_pkg::VEC_PAGE_SPEC : reset_seq_pkg::VEC_PAGE_NORM,
               reset_seq_pkg::VEC_LO_CMON}, 2'h1, 16);
        check("sample delay", 16'h1, 16'(n >= 2 * EDIV && n <= 2 * EDIV + 4));
    endtask

    task automatic pin_reset;
        special_mode = 1'b0;
        tick(4);
        hold_low = 1'b1;
        wait_until(2, 1'b1, 8);
        wait_until(2, 1'b0, 40);
        check("pin drive width", 16'(4 * EDIV), 16'(n));
        tick(60);
        check("held by pin", 16'h1, 16'(core_reset));
        check("external cause", 16'h0, 16'(reset_cause));
        hold_low = 1'b0;
        fetch({reset_seq_pkg::VEC_PAGE_NORM, reset_seq_pkg::VEC_LO_EXT}, 2'h0, 8);
    endtask

    task automatic watchdog_runs;
        watchdog_disable = 1'b0;
        repeat (5) begin
            service(reset_seq_pkg::WDG_KEY_ARM);
            tick(10);
            service(reset_seq_pkg::WDG_KEY_CLEAR);
            tick(30);
            check("serviced", 16'h0, 16'(core_reset));
        end
        // Clear key without arming must not restart the count
        service(reset_seq_pkg::WDG_KEY_CLEAR);
        wait_until(0, 1'b1, 60);
        check("unarmed clear ignored", 16'h1, 16'(n < 45));
        fetch({reset_seq_pkg::VEC_PAGE_NORM, reset_seq_pkg::VEC_LO_WDG}, 2'h2, 40);
        rate_wr = 1'b1;
        rate_data = 2'h1;
        tick(1);
        rate_wr = 1'b0;
        wait_until(0, 1'b1, 400);
        check("rate one period", 16'h1, 16'(n >= 240 && n <= 270));
        fetch({reset_seq_pkg::VEC_PAGE_NORM, reset_seq_pkg::VEC_LO_WDG}, 2'h2, 40);
        watchdog_disable = 1'b1;
        tick(200);
        check("disabled watchdog", 16'h0, 16'(core_reset));
    endtask

    initial begin
        error_cnt = 0;
        checked = 0;
        rst_b = 1'b0;
        hold_low = 1'b0;
        clk_fail = 1'b0;
        special_mode = 1'b0;
        watchdog_disable = 1'b1;
        service_wr = 1'b0;
        service_data = 8'h00;
        rate_wr = 1'b0;
        rate_data = 2'h0;
        tick(3);
        rst_b = 1'b1;
        por_delay();
        por_hold();
        clock_fail_reset(1'b0);
        clock_fail_reset(1'b1);
        pin_reset();
        watchdog_runs();
        end_sim();
    end
endmodule
`default_nettype wire
